/* hdl/gcgc_pkg.sv */
// Constants for the generic clock generator control block.
// Assumes an AHB-Lite master with 32-bit data and word-only accesses.
package gcgc_pkg;
	localparam int unsigned GCGC_NGEN = 9;
	localparam int unsigned GCGC_ID_W = 4;
	localparam int unsigned GCGC_SRC_W = 5;
	localparam int unsigned GCGC_DIV_W = 16;
	localparam int unsigned GCGC_FAC_W = 18;
	localparam int unsigned GCGC_ADR_W = 8;
	// Register byte offsets.
	localparam logic [7:0] GCGC_OFS_CTRL = 8'h04;
	localparam logic [7:0] GCGC_OFS_DIV = 8'h08;
	localparam logic [7:0] GCGC_OFS_PROT = 8'h0c;
	localparam logic [7:0] GCGC_OFS_STAT = 8'h10;
	// Control fields.
	localparam int unsigned GCGC_RS_BIT = 21;
	localparam int unsigned GCGC_DS_BIT = 20;
	localparam int unsigned GCGC_OE_BIT = 19;
	localparam int unsigned GCGC_OOV_BIT = 18;
	localparam int unsigned GCGC_IDC_BIT = 17;
	localparam int unsigned GCGC_EN_BIT = 16;
	localparam int unsigned GCGC_SRC_LSB = 8;
	localparam int unsigned GCGC_DIV_LSB = 8;
	localparam int unsigned GCGC_LOCK_LSB = 0;
	localparam int unsigned GCGC_RTC_LSB = 16;
	localparam int unsigned GCGC_STAT_CLK_LSB = 16;
	localparam int unsigned GCGC_HTRANS_ACT_BIT = 1;
	// Source codes and the generator numbers with special handling.
	localparam logic [4:0] GCGC_SRC_CRYSTAL_OSCILLATOR = 5'h00;
	localparam logic [4:0] GCGC_SRC_INPUT_PAD = 5'h01;
	localparam logic [4:0] GCGC_SRC_GENERATOR_ONE = 5'h02;
	localparam logic [4:0] GCGC_SRC_ULTRA_LOW_POWER_32K = 5'h03;
	localparam logic [4:0] GCGC_SRC_INTERNAL_32K = 5'h04;
	localparam logic [4:0] GCGC_SRC_CRYSTAL_32K = 5'h05;
	localparam logic [4:0] GCGC_SRC_INTERNAL_8MHZ = 5'h06;
	localparam logic [4:0] GCGC_SRC_FLL = 5'h07;
	localparam logic [4:0] GCGC_SRC_PLL = 5'h08;
	localparam logic [4:0] GCGC_SRC_MAX = GCGC_SRC_PLL;
	localparam int unsigned GCGC_GEN_ONE = 1;
	localparam int unsigned GCGC_GEN_TWO = 2;
	// Division widths per generator and power-of-two ceiling.
	localparam int unsigned GCGC_DIVW_GEN1 = 16;
	localparam int unsigned GCGC_DIVW_GEN2 = 5;
	localparam int unsigned GCGC_DIVW_OTHER = 8;
	localparam int unsigned GCGC_POW2_MAX_EXP = 17;
endpackage

/* hdl/gcgc_top.sv */
// Generic clock generator control: nine generators behind an AHB-Lite slave.
// Assumes clock sources arrive as levels synchronous to hclk and user reset is a pulse.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module gcgc_top
	import gcgc_pkg::*;
(
	// Clock and power reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// System
	input wire logic user_reset_req,
	input wire logic standby,
	input wire logic [gcgc_pkg::GCGC_NGEN-1:0] periph_req,
	input wire logic [gcgc_pkg::GCGC_NGEN-1:0] src_level,
	// Dedicated generator pins and outputs
	input wire logic [gcgc_pkg::GCGC_NGEN-1:0] generator_pin_i,
	output wire logic [gcgc_pkg::GCGC_NGEN-1:0] generator_pin_o,
	output wire logic [gcgc_pkg::GCGC_NGEN-1:0] generator_pin_oe,
	output wire logic [gcgc_pkg::GCGC_NGEN-1:0] gen_clk
);
	import gcgc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration state.
	logic [GCGC_NGEN-1:0] run_in_standby_q, divide_select_q, output_enable_q;
	logic [GCGC_NGEN-1:0] output_off_value_q, duty_cycle_improve_q, generator_enable_q;
	logic [GCGC_SRC_W-1:0] source_select_q [GCGC_NGEN];
	logic [GCGC_DIV_W-1:0] generator_division_q [GCGC_NGEN];
	logic [GCGC_NGEN-1:0] write_lock_q, rtc_use_q;
	logic [GCGC_ID_W-1:0] ctrl_sel_q, div_sel_q;
	logic [GCGC_NGEN-1:0] active_w;
	logic [GCGC_ADR_W-1:0] addr_q;
	logic wr_q, rd_q, hreadyout_q, hresp_q;
	logic [31:0] hrdata_q;
	logic take;

	function automatic logic [GCGC_SRC_W-1:0] rst_src(input int unsigned g);
		if (g == 0) begin
			return GCGC_SRC_INTERNAL_8MHZ;
		end
		if (g == GCGC_GEN_TWO) begin
			return GCGC_SRC_ULTRA_LOW_POWER_32K;
		end
		return GCGC_SRC_CRYSTAL_OSCILLATOR;
	endfunction

	function automatic logic [GCGC_DIV_W-1:0] div_mask(input int unsigned g);
		int unsigned w;
		w = (g == GCGC_GEN_ONE) ? GCGC_DIVW_GEN1 :
			(g == GCGC_GEN_TWO) ? GCGC_DIVW_GEN2 : GCGC_DIVW_OTHER;
		return GCGC_DIV_W'((32'h1 << w) - 32'h1);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: reads take one wait state so that a write in the previous data
	// phase is always visible to the read that follows it.
	assign take = hsel & htrans[GCGC_HTRANS_ACT_BIT] & hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= '0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (hready) begin
			addr_q <= haddr[GCGC_ADR_W-1:0];
			wr_q <= take & hwrite;
			rd_q <= take & ~hwrite;
		end else begin
			rd_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hreadyout_q <= ~(take & ~hwrite);
			hresp_q <= 1'b0;
		end
	end

	function automatic logic [31:0] read_word(input logic [GCGC_ADR_W-1:0] a);
		logic [31:0] r;
		r = '0;
		unique case (a)
			GCGC_OFS_CTRL: begin
				r[GCGC_ID_W-1:0] = ctrl_sel_q;
				if (ctrl_sel_q < GCGC_ID_W'(GCGC_NGEN)) begin
					r[GCGC_RS_BIT] = run_in_standby_q[ctrl_sel_q];
					r[GCGC_DS_BIT] = divide_select_q[ctrl_sel_q];
					r[GCGC_OE_BIT] = output_enable_q[ctrl_sel_q];
					r[GCGC_OOV_BIT] = output_off_value_q[ctrl_sel_q];
					r[GCGC_IDC_BIT] = duty_cycle_improve_q[ctrl_sel_q];
					r[GCGC_EN_BIT] = generator_enable_q[ctrl_sel_q];
					r[GCGC_SRC_LSB +: GCGC_SRC_W] = source_select_q[ctrl_sel_q];
				end
			end
			GCGC_OFS_DIV: begin
				r[GCGC_ID_W-1:0] = div_sel_q;
				if (div_sel_q < GCGC_ID_W'(GCGC_NGEN)) begin
					r[GCGC_DIV_LSB +: GCGC_DIV_W] = generator_division_q[div_sel_q];
				end
			end
			GCGC_OFS_PROT: begin
				r[GCGC_LOCK_LSB +: GCGC_NGEN] = write_lock_q;
				r[GCGC_RTC_LSB +: GCGC_NGEN] = rtc_use_q;
			end
			GCGC_OFS_STAT: begin
				r[GCGC_NGEN-1:0] = active_w;
				r[GCGC_STAT_CLK_LSB +: GCGC_NGEN] = gen_clk;
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (rd_q) begin
			hrdata_q <= read_word(addr_q);
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and the two resets. A user reset beats a write in the same
	// cycle, since software cannot rely on a write racing a system reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int unsigned g = 0; g < GCGC_NGEN; g++) begin
				run_in_standby_q[g] <= 1'b0;
				divide_select_q[g] <= 1'b0;
				output_enable_q[g] <= 1'b0;
				output_off_value_q[g] <= 1'b0;
				duty_cycle_improve_q[g] <= 1'b0;
				generator_enable_q[g] <= (g == 0) || (g == GCGC_GEN_TWO);
				source_select_q[g] <= rst_src(g);
				generator_division_q[g] <= '0;
			end
			write_lock_q <= '0;
			rtc_use_q <= '0;
			ctrl_sel_q <= '0;
			div_sel_q <= '0;
		end else if (user_reset_req) begin
			for (int unsigned g = 0; g < GCGC_NGEN; g++) begin
				if (g == 0 || !(write_lock_q[g] || rtc_use_q[g])) begin
					run_in_standby_q[g] <= 1'b0;
					divide_select_q[g] <= 1'b0;
					output_enable_q[g] <= 1'b0;
					output_off_value_q[g] <= 1'b0;
					duty_cycle_improve_q[g] <= 1'b0;
					generator_enable_q[g] <= (g == 0) || (g == GCGC_GEN_TWO);
					source_select_q[g] <= rst_src(g);
					generator_division_q[g] <= '0;
				end
			end
		end else if (wr_q && hready) begin
			unique case (addr_q)
				GCGC_OFS_CTRL: begin
					ctrl_sel_q <= hwdata[GCGC_ID_W-1:0];
					for (int unsigned g = 0; g < GCGC_NGEN; g++) begin
						if (hwdata[GCGC_ID_W-1:0] == GCGC_ID_W'(g)) begin
							run_in_standby_q[g] <= hwdata[GCGC_RS_BIT];
							divide_select_q[g] <= hwdata[GCGC_DS_BIT];
							output_enable_q[g] <= hwdata[GCGC_OE_BIT];
							output_off_value_q[g] <= hwdata[GCGC_OOV_BIT];
							duty_cycle_improve_q[g] <= hwdata[GCGC_IDC_BIT];
							generator_enable_q[g] <= hwdata[GCGC_EN_BIT];
							source_select_q[g] <= hwdata[GCGC_SRC_LSB +: GCGC_SRC_W];
						end
					end
				end
				GCGC_OFS_DIV: begin
					div_sel_q <= hwdata[GCGC_ID_W-1:0];
					for (int unsigned g = 0; g < GCGC_NGEN; g++) begin
						if (hwdata[GCGC_ID_W-1:0] == GCGC_ID_W'(g)) begin
							generator_division_q[g] <= hwdata[GCGC_DIV_LSB +: GCGC_DIV_W]
								& div_mask(g);
						end
					end
				end
				GCGC_OFS_PROT: begin
					write_lock_q <= hwdata[GCGC_LOCK_LSB +: GCGC_NGEN];
					rtc_use_q <= hwdata[GCGC_RTC_LSB +: GCGC_NGEN];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Generators. Each counts source half-periods unless bypassed (DS clear, division 0 or 1); a source
	// edge is any change of its sampled level, so the output can never toggle faster than hclk allows.
	for (genvar g = 0; g < GCGC_NGEN; g++) begin : gen_g
		logic [GCGC_SRC_W-1:0] s;
		logic lvl, lvl_q, clk_q, pin_o_q, pin_oe_q, pad_src, oe_eff, bypass;
		logic [GCGC_FAC_W-1:0] fac;
		logic [GCGC_FAC_W:0] per, hi, h_q, h_inc;
		logic [4:0] expo;

		assign s = source_select_q[g];
		assign pad_src = (s == GCGC_SRC_INPUT_PAD);
		assign oe_eff = output_enable_q[g] & ~pad_src;
		assign active_w[g] = generator_enable_q[g] & (periph_req[g] | oe_eff)
			& (~standby | (run_in_standby_q[g] & oe_eff));

		always_comb begin
			if (pad_src) begin
				lvl = generator_pin_i[g];
			end else if (s == GCGC_SRC_GENERATOR_ONE) begin
				lvl = gen_clk[GCGC_GEN_ONE];
			end else if (s <= GCGC_SRC_MAX) begin
				lvl = src_level[s[GCGC_ID_W-1:0]];
			end else begin
				lvl = 1'b0;
			end
		end

		always_comb begin
			expo = 5'(GCGC_POW2_MAX_EXP);
			if (generator_division_q[g] < GCGC_DIV_W'(GCGC_POW2_MAX_EXP)) begin
				expo = generator_division_q[g][4:0] + 5'h1;
			end
			if (divide_select_q[g]) begin
				fac = GCGC_FAC_W'(18'h1 << expo);
			end else begin
				fac = GCGC_FAC_W'(generator_division_q[g]);
			end
			bypass = ~divide_select_q[g] & (generator_division_q[g] <= GCGC_DIV_W'(1));
			per = {fac, 1'b0};
			hi = (duty_cycle_improve_q[g] | ~fac[0]) ? {1'b0, fac} : {1'b0, fac} - 19'h1;
			h_inc = h_q + 19'h1;
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				lvl_q <= 1'b0;
			end else begin
				lvl_q <= lvl;
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				h_q <= '0;
				clk_q <= 1'b0;
			end else if (!active_w[g]) begin
				h_q <= '0;
				clk_q <= 1'b0;
			end else if (bypass) begin
				h_q <= '0;
				clk_q <= lvl;
			end else if (lvl != lvl_q) begin
				h_q <= (h_inc >= per) ? '0 : h_inc;
				clk_q <= (h_q < hi);
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				pin_o_q <= 1'b0;
				pin_oe_q <= 1'b0;
			end else begin
				pin_oe_q <= ~pad_src;
				pin_o_q <= (active_w[g] & oe_eff) ? clk_q : output_off_value_q[g];
			end
		end

		assign gen_clk[g] = clk_q;
		assign generator_pin_o[g] = pin_o_q;
		assign generator_pin_oe[g] = pin_oe_q;
	end
endmodule

/* tb/gcgc_sva.sv */
// Bus timing and pin checks on the clock generator control top.
// Assumes hready is the slave's own hreadyout, as with one slave.
`timescale 1ns/1ns
module gcgc_sva
	import gcgc_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins
	input wire logic [gcgc_pkg::GCGC_NGEN-1:0] generator_pin_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	assign take = hsel && htrans[1] && hready;
////////////////////////////////////////////////////////////////////////////////
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase has wrong length");
	write_ready_a: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	wait_single_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	idle_ready_a: assert property (!take && hreadyout |=> hreadyout)
		else $error("wait state without a transfer");
	ready_cause_a: assert property ($fell(hreadyout) |-> $past(take) && !$past(hwrite))
		else $error("wait state not caused by a read");
	rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data changed outside a read");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	// No reset value selects the pad, so every pin must be driven.
	pin_drive_a: assert property ($rose(hresetn) |=> generator_pin_oe == '1)
		else $error("pin not driven after reset");
endmodule
bind gcgc_top gcgc_sva gcgc_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .generator_pin_oe(generator_pin_oe));

/* tb/gcgc_tb.sv */
// Self-checking bench for the clock generator control block.
// Assumes sources are hclk-synchronous levels; source 6 toggles every cycle.
`timescale 1ns/1ns
module gcgc_tb;
	import gcgc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, urst, stby;
	// The 8 MHz stand-in has a single driver, so it starts from its declaration.
	logic osc = 1'b0;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, rd;
	logic [8:0] preq, src, pin_i;
	wire [31:0] hrdata;
	wire hreadyout, hresp;
	wire [8:0] pin_o, pin_oe, gclk;
	int n_fail, total_checks;
	logic [31:0] tc[4] = '{32'h00030605, 32'h00010605, 32'h00110605, 32'h00010605};
	logic [31:0] td[4] = '{32'h305, 32'h305, 32'h105, 32'h105};
	int tl[4] = '{24, 24, 32, 8};
	int te[4] = '{12, 8, 16, 4};
	logic [31:0] pc[5] = '{32'h90605, 32'h90605, 32'hd0605, 32'h2d0605, 32'h250605};
	int pe[5] = '{4, 0, 8, 4, 8};
	gcgc_top gcgc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.user_reset_req(urst), .standby(stby), .periph_req(preq),
		.src_level({src[8:7], osc, src[5:0]}), .generator_pin_i(pin_i),
		.generator_pin_o(pin_o), .generator_pin_oe(pin_oe), .gen_clk(gclk));
////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) osc <= ~osc;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Windows span whole periods, so the count of high cycles is phase free.
	task automatic cnt(input int g, input bit p, input int len, input int exp);
		int k;
		logic v;
		k = 0;
		repeat (16) @(posedge hclk);
		repeat (len) begin
			@(posedge hclk);
			v = p ? pin_o[g] : gclk[g];
			if (v !== 1'b0) k += (v === 1'b1) ? 1 : 99;
		end
		chk(k, exp);
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
////////////////////////////////////////////////////////////////////////////////
	initial begin
		{hresetn, hsel, htrans, haddr, hwrite, hwdata, urst, stby} = '0;
		{preq, src, pin_i} = {9'h1ff, 9'h008, 9'h1ff};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		acc(8'h04, 0, 0);
		chk(rd, 32'h00010600);
		cnt(2, 0, 8, 8);
		cnt(3, 0, 8, 0);
		for (int i = 1; i < 4; i++) begin
			acc(8'h08, 1, {8'h0, 16'hffff, 4'h0, 4'(i)});
			acc(8'h08, 0, 0);
			chk(rd, {8'h0, i == 1 ? 16'hffff : i == 2 ? 16'h1f : 16'hff, 4'h0, 4'(i)});
		end
		acc(8'h40, 1, 32'hffffffff);
		acc(8'h40, 0, 0);
		chk(rd, 0);
		acc(8'h04, 1, 32'h003f0704);
		acc(8'h04, 0, 0);
		chk(rd, 32'h003f0704);
		// Generator 3 still holds the wide factor from above, so clear it for the sweep.
		acc(8'h08, 1, 32'h00000003);
		src <= 9'h1ff;
		for (int c = 0; c < 10; c++) begin
			acc(8'h04, 1, {16'h0001, 3'h0, 5'(c), 8'h03});
			cnt(3, 0, 8, c == 6 ? 4 : (c == 2 || c == 9) ? 0 : 8);
			chk(32'(pin_oe[3]), 32'(c != 1));
		end
		for (int i = 0; i < 4; i++) begin
			acc(8'h08, 1, td[i]);
			acc(8'h04, 1, tc[i]);
			cnt(5, 0, tl[i], te[i]);
		end
		for (int i = 0; i < 5; i++) begin
			stby <= (i > 0);
			preq[5] <= (i == 4);
			acc(8'h04, 1, pc[i]);
			cnt(5, 1, 8, pe[i]);
		end
		cnt(5, 0, 8, 0);
		stby <= 1'b0;
		foreach (tc[i]) acc(8'h04, 1, 32'h00010604 + 32'(i));
		acc(8'h0c, 1, 32'h00800010);
		acc(8'h0c, 0, 0);
		chk(rd, 32'h00800010);
		acc(8'h04, 1, 0);
		urst <= 1'b1;
		@(posedge hclk);
		urst <= 1'b0;
		acc(8'h04, 0, 0);
		chk(rd, 32'h00010600);
		cnt(4, 0, 8, 4);
		cnt(6, 0, 8, 0);
		cnt(7, 0, 8, 4);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		acc(8'h0c, 0, 0);
		chk(rd, 0);
		cnt(4, 0, 8, 0);
		// Generator 0 follows the toggling source, so its clock level is masked.
		acc(8'h10, 0, 0);
		chk(rd & 32'hfffeffff, 32'h00040005);
		finish_test;
	end
endmodule
